/* File: port_ansel_pkg.sv */
// Package: register map, field masks and carrier types for the analog-select block
package port_ansel_pkg;

  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned PORT_W     = 8;

  // Register byte addresses on the peripheral bus
  localparam logic [11:0] PORT_B_ANALOG_SELECT_OFS = 12'h000;
  localparam logic [11:0] PORT_C_ANALOG_SELECT_OFS = 12'h004;
  localparam logic [11:0] PORT_B_STATUS_OFS        = 12'h008;
  localparam logic [11:0] PORT_C_STATUS_OFS        = 12'h00c;

  // Implemented select bits: port B 5..0, port C 7..2
  localparam logic [7:0]  PORT_B_IMPL_MASK  = 8'h3f;
  localparam logic [7:0]  PORT_C_IMPL_MASK  = 8'hfc;

  // Implemented bits come out of reset set, unimplemented ones clear
  localparam logic [7:0]  PORT_B_RESET      = 8'h3f;
  localparam logic [7:0]  PORT_C_RESET      = 8'hfc;

  // Pin-side signals of one 8-bit port
  typedef struct packed {
    logic [7:0] pin_in;
    logic [7:0] latch;
    logic [7:0] out_dir;
  } port_pins_t;

  // Per-port results toward the pins and the read path
  typedef struct packed {
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] in_buf_en;
    logic [7:0] input_value;
  } port_view_t;

endpackage : port_ansel_pkg

/* File: port_ansel_lane.sv */
// One port's pin path: input buffer gating and unchanged output drive
`timescale 1ns/1ps
module port_ansel_lane #(
  parameter logic [7:0] IMPL_MASK = 8'hff
) (
  // Clock and reset
  input  wire logic                   ref_clk_in,
  input  wire logic                   rst_in,
  // Control and pins
  input  wire logic [7:0]             analog_sel_in,
  input  port_ansel_pkg::port_pins_t  pins_in,
  output wire port_ansel_pkg::port_view_t view_out
);

  logic [7:0] buf_en;
  logic [7:0] input_value_r;
  logic [7:0] input_value_nxt;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      // A set select bit disables the digital input buffer
      assign buf_en[i] = IMPL_MASK[i] ? ~analog_sel_in[i] : 1'b1;
      // Disabled buffer reads as zero so the analog level never leaks in
      assign input_value_nxt[i] = buf_en[i] & pins_in.pin_in[i];
    end
  endgenerate

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      input_value_r <= 8'h00;
    end else begin
      input_value_r <= input_value_nxt;
    end
  end

  // Output drive ignores the select bit entirely
  assign view_out.pin_out     = pins_in.latch;
  assign view_out.pin_oe      = pins_in.out_dir;
  assign view_out.in_buf_en   = buf_en;
  assign view_out.input_value = input_value_r;

endmodule : port_ansel_lane

/* File: port_analog_input_select.sv */
// Top: APB register file for the analog-select bits of ports B and C
`timescale 1ns/1ps

// Function
// - Port B pins 5..0: select bit 1 disables input buffer, 0 enables it.
// - Port B select bits 7 and 6 ignore writes and read zero.
// - Port C pins 7..2: select bit 1 disables input buffer, 0 enables it.
// - Port C select bits 1 and 0 ignore writes and read zero.
// - Digital output keeps driving its latch value whatever the select bit.
// - With select set, the pin's digital input is blocked from the read path.
module port_analog_input_select (
  // Clock and reset
  input  wire logic                   ref_clk_in,
  input  wire logic                   rst_in,
  // APB slave
  input  wire logic                   psel_in,
  input  wire logic                   penable_in,
  input  wire logic                   pwrite_in,
  input  wire logic [11:0]            paddr_in,
  input  wire logic [31:0]            pwdata_in,
  input  wire logic [3:0]             pstrb_in,
  output logic      [31:0]            prdata_out,
  output logic                        pready_out,
  output logic                        pslverr_out,
  // Port B pins
  input  port_ansel_pkg::port_pins_t  port_b_pins_in,
  output port_ansel_pkg::port_view_t  port_b_view_out,
  // Port C pins
  input  port_ansel_pkg::port_pins_t  port_c_pins_in,
  output port_ansel_pkg::port_view_t  port_c_view_out
);

  logic [7:0]  port_b_analog_select_r;
  logic [7:0]  port_b_analog_select_nxt;
  logic [7:0]  port_c_analog_select_r;
  logic [7:0]  port_c_analog_select_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pslverr_r;

  // Decode
  wire access_w  = psel_in & penable_in;
  wire hit_b     = (paddr_in == port_ansel_pkg::PORT_B_ANALOG_SELECT_OFS);
  wire hit_c     = (paddr_in == port_ansel_pkg::PORT_C_ANALOG_SELECT_OFS);
  wire hit_bs    = (paddr_in == port_ansel_pkg::PORT_B_STATUS_OFS);
  wire hit_cs    = (paddr_in == port_ansel_pkg::PORT_C_STATUS_OFS);
  wire mapped    = hit_b | hit_c | hit_bs | hit_cs;
  // Status registers are read-only, so a write there is an error too
  wire bad       = ~mapped | (pwrite_in & (hit_bs | hit_cs));
  // Qualified by pready so a write lands once, at the edge the master samples it
  wire wr_b      = pready_out & pwrite_in & hit_b & pstrb_in[0];
  wire wr_c      = pready_out & pwrite_in & hit_c & pstrb_in[0];

  // Unimplemented positions are masked off on every write
  assign port_b_analog_select_nxt = wr_b ?
      (pwdata_in[7:0] & port_ansel_pkg::PORT_B_IMPL_MASK) : port_b_analog_select_r;
  assign port_c_analog_select_nxt = wr_c ?
      (pwdata_in[7:0] & port_ansel_pkg::PORT_C_IMPL_MASK) : port_c_analog_select_r;

  // Read mux; status shows live buffer enables and gated input values
  wire [7:0] sel_b_rd = port_b_analog_select_r & port_ansel_pkg::PORT_B_IMPL_MASK;
  wire [7:0] sel_c_rd = port_c_analog_select_r & port_ansel_pkg::PORT_C_IMPL_MASK;
  wire [15:0] stat_b  = {port_b_view_out.in_buf_en, port_b_view_out.input_value};
  wire [15:0] stat_c  = {port_c_view_out.in_buf_en, port_c_view_out.input_value};

  assign prdata_nxt = (access_w & ~pwrite_in & hit_b)  ? {24'h000000, sel_b_rd} :
                      (access_w & ~pwrite_in & hit_c)  ? {24'h000000, sel_c_rd} :
                      (access_w & ~pwrite_in & hit_bs) ? {16'h0000, stat_b}      :
                      (access_w & ~pwrite_in & hit_cs) ? {16'h0000, stat_c}      :
                      32'h00000000;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      port_b_analog_select_r <= port_ansel_pkg::PORT_B_RESET;
      port_c_analog_select_r <= port_ansel_pkg::PORT_C_RESET;
    end else begin
      port_b_analog_select_r <= port_b_analog_select_nxt;
      port_c_analog_select_r <= port_c_analog_select_nxt;
    end
  end

  // One wait state: data and error are registered, answer in the second access cycle
  logic ack_r;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ack_r     <= 1'b0;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      ack_r     <= access_w & ~ack_r;
      prdata_r  <= prdata_nxt;
      pslverr_r <= access_w & bad;
    end
  end

  // Write lands on the edge where pready is seen; gate writes accordingly
  assign pready_out  = ack_r & access_w;
  assign prdata_out  = pready_out ? prdata_r : 32'h00000000;
  assign pslverr_out = pready_out & pslverr_r;

  port_ansel_lane #(
    .IMPL_MASK (port_ansel_pkg::PORT_B_IMPL_MASK)
  ) u_lane_b (
    .ref_clk_in    (ref_clk_in),
    .rst_in        (rst_in),
    .analog_sel_in (port_b_analog_select_r),
    .pins_in       (port_b_pins_in),
    .view_out      (port_b_view_out)
  );

  port_ansel_lane #(
    .IMPL_MASK (port_ansel_pkg::PORT_C_IMPL_MASK)
  ) u_lane_c (
    .ref_clk_in    (ref_clk_in),
    .rst_in        (rst_in),
    .analog_sel_in (port_c_analog_select_r),
    .pins_in       (port_c_pins_in),
    .view_out      (port_c_view_out)
  );

endmodule : port_analog_input_select

/* File: port_analog_input_select_props.sv */
// Checker: port properties of the analog-select block
`timescale 1ns/1ps
module port_analog_input_select_props (
  input wire logic                  ref_clk_in, rst_in, psel_in, penable_in, pwrite_in,
  input wire logic                  pready_out,
  input wire logic [11:0]           paddr_in,
  input wire logic [31:0]           pwdata_in, prdata_out,
  input wire logic [3:0]            pstrb_in,
  input port_ansel_pkg::port_pins_t port_b_pins_in, port_c_pins_in,
  input port_ansel_pkg::port_view_t port_b_view_out, port_c_view_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  wire wr_ok = pready_out && pwrite_in && pstrb_in[0];
  wire rd_ok = pready_out && !pwrite_in;
  sequence setup_s; psel_in && !penable_in; endsequence
  sequence ack_s; psel_in && penable_in && !pready_out ##1 pready_out; endsequence
  one_wait_a: assert property (setup_s |=> ack_s) else $error("wait state wrong");
  b_write_a: assert property (wr_ok && paddr_in == 12'h000 |=>
    port_b_view_out.in_buf_en[5:0] == ~$past(pwdata_in[5:0])) else $error("B select lost");
  c_write_a: assert property (wr_ok && paddr_in == 12'h004 |=>
    port_c_view_out.in_buf_en[7:2] == ~$past(pwdata_in[7:2])) else $error("C select lost");
  b_unimpl_a: assert property (rd_ok && paddr_in == 12'h000 |-> prdata_out[31:6] == 26'h0
    && port_b_view_out.in_buf_en[7:6] == 2'h3) else $error("B spare bits wrong");
  c_unimpl_a: assert property (rd_ok && paddr_in == 12'h004 |-> prdata_out[1:0] == 2'h0
    && port_c_view_out.in_buf_en[1:0] == 2'h3) else $error("C spare bits wrong");
  drive_kept_a: assert property (port_b_view_out.pin_out == port_b_pins_in.latch
    && port_b_view_out.pin_oe == port_b_pins_in.out_dir
    && port_c_view_out.pin_out == port_c_pins_in.latch
    && port_c_view_out.pin_oe == port_c_pins_in.out_dir) else $error("output drive changed");
  input_gate_a: assert property (!$past(rst_in) |-> port_b_view_out.input_value ==
    ($past(port_b_pins_in.pin_in) & $past(port_b_view_out.in_buf_en))) else $error("gate bad");
  reset_sel_a: assert property ($fell(rst_in) |-> port_b_view_out.in_buf_en == 8'hc0
    && port_c_view_out.in_buf_en == 8'h03) else $error("select reset value wrong");
endmodule : port_analog_input_select_props

/* File: port_analog_input_select_bench.sv */
// Bench: APB and pin stimulus with queued expectations
`timescale 1ns/1ps
module port_analog_input_select_bench;
  logic ref_clk_in, rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, v;
  logic [3:0]  pstrb_in;
  logic [7:0]  eb, ec;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int          failures, check_count, cyc;
  port_ansel_pkg::port_pins_t pb, pc;
  port_ansel_pkg::port_view_t vb, vc;
  port_analog_input_select uut (.ref_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out,
    .port_b_pins_in(pb), .port_b_view_out(vb), .port_c_pins_in(pc), .port_c_view_out(vc));
  task automatic final_report;
    if (failures == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  // Request is held until pready is seen; next setup may follow at once
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [33:0] x);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    {pwrite_in, paddr_in, pwdata_in, pstrb_in} <= {w, a, d, s};
    exp_q.push_back(x);
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    @(posedge ref_clk_in iff pready_out === 1'b1);
  endtask : xfer
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    pb.latch <= 8'($urandom);
    pb.out_dir <= 8'($urandom);
    pc.latch <= 8'($urandom);
    pc.out_dir <= 8'($urandom);
    if (cyc == 3000) begin
      failures++;
      final_report;
    end
    if (!rst_in) begin
      check_count++;
      if (vb.pin_out !== pb.latch || vb.pin_oe !== pb.out_dir ||
          vc.pin_out !== pc.latch || vc.pin_oe !== pc.out_dir) begin
        failures++;
        $display("ERROR %0t: output drive changed", $time);
      end
    end
    if (!rst_in && pready_out === 1'b1) begin
      e = exp_q.pop_front();
      check_count++;
      if (pslverr_out !== e[32] || (e[33] && prdata_out !== e[31:0])) begin
        failures++;
        $display("ERROR %0t: got %h expected %h", $time, {pslverr_out, prdata_out}, e);
      end
    end
  end
  initial begin
    void'($urandom(5463));
    {rst_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, pstrb_in} = 'h1;
    {rst_in, cyc, pb, pc} = {1'b1, 32'h0, 24'($urandom), 24'($urandom)};
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    xfer(1'b0, 12'h000, 32'h0, 4'hf, {2'b10, 32'h3f});
    xfer(1'b0, 12'h00c, 32'h0, 4'hf, {2'b10, 16'h0000, 8'h03, pc.pin_in & 8'h03});
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 32'hff : $urandom;
      eb = {2'b11, ~v[5:0]};
      ec = {~v[7:2], 2'b11};
      xfer(1'b1, 12'h000, v, 4'h1, 34'h0);
      xfer(1'b1, 12'h004, v, 4'h1, 34'h0);
      xfer(1'b0, 12'h000, 32'h0, 4'h1, {2'b10, 26'h0000000, v[5:0]});
      xfer(1'b0, 12'h004, 32'h0, 4'h1, {26'h200_0000, v[7:2], 2'h0});
      xfer(1'b0, 12'h008, 32'h0, 4'h1, {18'h2_0000, eb, pb.pin_in & eb});
      xfer(1'b0, 12'h00c, 32'h0, 4'h1, {18'h2_0000, ec, pc.pin_in & ec});
    end
    xfer(1'b1, 12'h008, 32'h0, 4'hf, {2'b01, 32'h0});
    xfer(1'b0, 12'h010, 32'h0, 4'hf, {2'b11, 32'h0});
    xfer(1'b1, 12'h000, 32'h0, 4'he, 34'h0);
    xfer(1'b0, 12'h000, 32'h0, 4'hf, {2'b10, 26'h0000000, v[5:0]});
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    final_report;
  end
endmodule : port_analog_input_select_bench
bind port_analog_input_select port_analog_input_select_props chk (.ref_clk_in, .rst_in,
  .psel_in, .penable_in, .pwrite_in, .pready_out, .paddr_in, .pwdata_in, .prdata_out,
  .pstrb_in, .port_b_pins_in, .port_c_pins_in, .port_b_view_out, .port_c_view_out);
